/* logic/aepc_pkg.sv */
/*
  constants for the absorb / equalize phase control block: command codes,
  field positions, reset values, charge voltage scaling and timing.
  assumes a 125 MHz system clock and a host on a two-wire register port.
*/
// How it works
// - base code 6 bits, 28.571mV steps, default 21
// - target scaled by cell factor N plus one
// - active code follows base outside absorb and equalize
// - compensation enable bit 1; off means base
// - signed taper threshold ends absorb phase
// - absorb code is base plus absorb adder
// - zero absorb adder skips absorb phase
// - servo target capped at 7.8V per cell
// - absorb compensation -11mV per degree per cell
// - equalize code is base plus equalize adder
// - equalize compensation -11.4mV per degree per cell
// - absorb limit 16-bit seconds, default 5400
// - absorb ends once timer exceeds limit
// - equalize limit 16-bit seconds, default 3600
// - equalize ends once timer reaches limit
// - equalize request self clears; host may cancel
// - phase indicator one-hot, 512 and 1024
package aepc_pkg;

  // command codes
  localparam logic [7:0]  CMD_CONFIG     = 8'h14;
  localparam logic [7:0]  CMD_VCHARGE    = 8'h1B;
  localparam logic [7:0]  CMD_TAPER      = 8'h1C;
  localparam logic [7:0]  CMD_TCOMP      = 8'h29;
  localparam logic [7:0]  CMD_ABS_ADD    = 8'h2A;
  localparam logic [7:0]  CMD_ABS_LIM    = 8'h2B;
  localparam logic [7:0]  CMD_EQ_ADD     = 8'h2C;
  localparam logic [7:0]  CMD_EQ_LIM     = 8'h2D;
  localparam logic [7:0]  CMD_ABS_TMR    = 8'h32;
  localparam logic [7:0]  CMD_EQ_TMR     = 8'h33;
  localparam logic [7:0]  CMD_STATE      = 8'h34;

  // field positions
  localparam int          CFG_EQREQ_BIT  = 0;
  localparam int          CFG_SUSP_BIT   = 5;
  localparam int          TCOMP_EN_BIT   = 1;

  // reset values
  localparam logic [5:0]  RST_VCHARGE    = 6'h15;
  localparam logic [15:0] RST_TAPER      = 16'h0888;
  localparam logic        RST_TCOMP      = 1'b1;
  localparam logic [5:0]  RST_ABS_ADD    = 6'h15;
  localparam logic [15:0] RST_ABS_LIM    = 16'h1518;
  localparam logic [5:0]  RST_EQ_ADD     = 6'h2A;
  localparam logic [15:0] RST_EQ_LIM     = 16'h0E10;
  localparam logic [15:0] TMR_MAX        = 16'hFFFF;
  localparam logic [5:0]  CODE_MAX       = 6'h3F;

  // one-hot phase indicator values
  localparam logic [12:0] ST_SUSPENDED   = 13'h0100;
  localparam logic [12:0] ST_CCCV        = 13'h0040;
  localparam logic [12:0] ST_ABSORB      = 13'h0200;
  localparam logic [12:0] ST_EQUALIZE    = 13'h0400;

  // per-cell voltage scaling in microvolts
  localparam int          FLOOR_UV       = 6000000;
  localparam int          STEP_UV        = 28571;
  localparam int          CAP_UV         = 7800000;
  localparam int          TC_ABS_UV_C    = 11000;
  localparam int          TC_EQ_UV_C     = 11400;
  localparam int          TC_REF_C       = 25;

  // one-second tick
  localparam int          CLK_PERIOD_NS  = 8;
  localparam int          TICK_PERIOD_S  = 1;
  localparam int          TICK_CYCLES    = TICK_PERIOD_S * 1000000000 / CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    AEPC_S_IDLE, AEPC_S_ADDR, AEPC_S_CMD, AEPC_S_WLO, AEPC_S_WHI, AEPC_S_RLO, AEPC_S_RHI
  } aepc_ser_t;

  typedef enum logic [1:0] {
    AEPC_P_SUSP, AEPC_P_CCCV, AEPC_P_ABSORB, AEPC_P_EQUAL
  } aepc_phase_t;

endpackage : aepc_pkg

/* logic/aepc_i2c_slave.sv */
/*
  two-wire register port slave: word write (addr, cmd, low, high) and
  word read (addr, cmd, repeated start, addr, low, high), low byte first.
  assumes a master that obeys standard start, stop and ack timing.
*/
`timescale 1ns/1ns
module aepc_i2c_slave
  import aepc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h68
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  input  wire logic [15:0] rd_data_in,
  output logic      [7:0]  cmd_out,
  output logic             wr_stb_out,
  output logic      [15:0] wr_data_out,
  output logic             sda_oe_out,
  output logic             sda_dat_out
);
  logic [2:0] scl_s, sda_s;
  logic       scl_f, sda_f, scl_p, sda_p;
  aepc_ser_t  st;
  logic [3:0] cnt;
  logic [7:0] sh, tx, hi, lo;
  logic       ack_r;
  logic       start, stop, rise, fall;

  // pins settle only once the second and third stage agree
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      sda_dat_out <= 1'b0;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      if (scl_s[2] == scl_s[1]) scl_f <= scl_s[2];
      if (sda_s[2] == sda_s[1]) sda_f <= sda_s[2];
      scl_p <= scl_f;
      sda_p <= sda_f;
      sda_dat_out <= 1'b0;
    end
  end

  assign start = scl_f & scl_p & sda_p & ~sda_f;
  assign stop  = scl_f & scl_p & ~sda_p & sda_f;
  assign rise  = scl_f & ~scl_p;
  assign fall  = ~scl_f & scl_p;

  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      st <= AEPC_S_IDLE;
      cnt <= 4'h0;
      sh <= 8'h00;
      tx <= 8'h00;
      hi <= 8'h00;
      lo <= 8'h00;
      ack_r <= 1'b1;
      cmd_out <= 8'h00;
      wr_stb_out <= 1'b0;
      wr_data_out <= 16'h0000;
      sda_oe_out <= 1'b0;
    end else begin
      wr_stb_out <= 1'b0;
      if (start) begin
        st <= AEPC_S_ADDR;
        cnt <= 4'h0;
        sda_oe_out <= 1'b0;
      end else if (stop) begin
        st <= AEPC_S_IDLE;
        sda_oe_out <= 1'b0;
      end else if (st != AEPC_S_IDLE) begin
        if (rise) begin
          if (cnt < 4'h8) sh <= {sh[6:0], sda_f};
          else ack_r <= sda_f;
          if (cnt < 4'h9) cnt <= cnt + 4'h1;
        end else if (fall && cnt == 4'h8) begin
          case (st)
            AEPC_S_ADDR: begin
              if (sh[7:1] == DEV_ADDR) sda_oe_out <= 1'b1;
              else st <= AEPC_S_IDLE;
            end
            AEPC_S_CMD, AEPC_S_WLO, AEPC_S_WHI: sda_oe_out <= 1'b1;
            default: sda_oe_out <= 1'b0;
          endcase
        end else if (fall && cnt == 4'h9) begin
          cnt <= 4'h0;
          sda_oe_out <= 1'b0;
          case (st)
            AEPC_S_ADDR: begin
              if (sh[0]) begin
                // whole word captured now so both bytes are coherent
                tx <= rd_data_in[7:0];
                hi <= rd_data_in[15:8];
                sda_oe_out <= ~rd_data_in[7];
                st <= AEPC_S_RLO;
              end else begin
                st <= AEPC_S_CMD;
              end
            end
            AEPC_S_CMD: begin
              cmd_out <= sh;
              st <= AEPC_S_WLO;
            end
            AEPC_S_WLO: begin
              lo <= sh;
              st <= AEPC_S_WHI;
            end
            AEPC_S_WHI: begin
              wr_stb_out <= 1'b1;
              wr_data_out <= {sh, lo};
              st <= AEPC_S_IDLE;
            end
            AEPC_S_RLO: begin
              if (!ack_r) begin
                tx <= hi;
                sda_oe_out <= ~hi[7];
                st <= AEPC_S_RHI;
              end else begin
                st <= AEPC_S_IDLE;
              end
            end
            default: st <= AEPC_S_IDLE;
          endcase
        end else if (fall && cnt != 4'h0 && (st == AEPC_S_RLO || st == AEPC_S_RHI)) begin
          tx <= {tx[6:0], 1'b0};
          sda_oe_out <= ~tx[6];
        end
      end
    end
  end

endmodule : aepc_i2c_slave

/* logic/aepc_ctl.sv */
/*
  absorb / equalize phase control: setpoint registers, servo code with cap
  and temperature compensation, one-second phase timers, phase sequencing.
  assumes ibat, temperature and the cv-reached flag come from logic on the
  same clock; the cell factor input is static while charging.
*/
`timescale 1ns/1ns
module aepc_ctl
  import aepc_pkg::*;
#(
  parameter int         TICK_CNT = TICK_CYCLES,
  parameter logic [6:0] DEV_ADDR = 7'h68
) (
  input  wire logic               CLK_IN,
  input  wire logic               RESETN_IN,
  input  wire logic               SCL_IN,
  input  wire logic               SDA_IN,
  output logic                    SDA_OUT,
  output logic                    SDA_OE_OUT,
  input  wire logic        [1:0]  CELL_FACTOR_IN,
  input  wire logic signed [15:0] IBAT_IN,
  input  wire logic signed [7:0]  BAT_TEMP_C_IN,
  input  wire logic               CV_REACHED_IN,
  output logic             [5:0]  SERVO_CODE_OUT,
  output logic             [25:0] VTARGET_UV_OUT,
  output logic             [12:0] CHARGER_STATE_OUT,
  output logic                    EQUALIZE_REQ_OUT
);
  logic [5:0]  vcharge_r, abs_add_r, eq_add_r;
  logic [15:0] taper_r, abs_lim_r, eq_lim_r, abs_tmr_r, eq_tmr_r;
  logic        tcomp_r, susp_r, eqreq_r, absorbed_r;
  logic [7:0]  cmd;
  logic        wr_stb;
  logic [15:0] wr_data, rd_data;
  aepc_phase_t ph_r, ph_nxt;
  logic [31:0] tick_cnt_r;
  logic        tick_r;
  logic [6:0]  sum_abs, sum_eq;
  logic [5:0]  code_nxt;
  logic        taper_hit, abs_done, eq_done;
  logic signed [31:0] cell_uv, comp, slope;

  aepc_i2c_slave #(
    .DEV_ADDR    (DEV_ADDR)
  ) u_port (
    .clk_in      (CLK_IN),
    .resetn_in   (RESETN_IN),
    .scl_in      (SCL_IN),
    .sda_in      (SDA_IN),
    .rd_data_in  (rd_data),
    .cmd_out     (cmd),
    .wr_stb_out  (wr_stb),
    .wr_data_out (wr_data),
    .sda_oe_out  (SDA_OE_OUT),
    .sda_dat_out (SDA_OUT)
  );

  // setpoint registers
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      vcharge_r <= RST_VCHARGE;
      taper_r   <= RST_TAPER;
      tcomp_r   <= RST_TCOMP;
      abs_add_r <= RST_ABS_ADD;
      abs_lim_r <= RST_ABS_LIM;
      eq_add_r  <= RST_EQ_ADD;
      eq_lim_r  <= RST_EQ_LIM;
      susp_r    <= 1'b0;
    end else if (wr_stb) begin
      case (cmd)
        CMD_VCHARGE: vcharge_r <= wr_data[5:0];
        CMD_TAPER:   taper_r   <= wr_data;
        CMD_TCOMP:   tcomp_r   <= wr_data[TCOMP_EN_BIT];
        CMD_ABS_ADD: abs_add_r <= wr_data[5:0];
        CMD_ABS_LIM: abs_lim_r <= wr_data;
        CMD_EQ_ADD:  eq_add_r  <= wr_data[5:0];
        CMD_EQ_LIM:  eq_lim_r  <= wr_data;
        CMD_CONFIG:  susp_r    <= wr_data[CFG_SUSP_BIT];
        default:     susp_r    <= susp_r;
      endcase
    end
  end

  // request self clear
  // a host write in the same cycle as the hardware clear is tested first, so it wins
  // keyed to the suspend bit, not the phase: a request written with the resume must survive
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      eqreq_r <= 1'b0;
    end else if (wr_stb && cmd == CMD_CONFIG) begin
      eqreq_r <= wr_data[CFG_EQREQ_BIT];
    end else if (susp_r || (ph_r == AEPC_P_EQUAL && eq_done)) begin
      eqreq_r <= 1'b0;
    end
  end

  // unmapped codes read as zero
  always_comb begin
    case (cmd)
      CMD_CONFIG:  rd_data = {10'h000, susp_r, 4'h0, eqreq_r};
      CMD_VCHARGE: rd_data = {10'h000, vcharge_r};
      CMD_TAPER:   rd_data = taper_r;
      CMD_TCOMP:   rd_data = {14'h0000, tcomp_r, 1'b0};
      CMD_ABS_ADD: rd_data = {10'h000, abs_add_r};
      CMD_ABS_LIM: rd_data = abs_lim_r;
      CMD_EQ_ADD:  rd_data = {10'h000, eq_add_r};
      CMD_EQ_LIM:  rd_data = eq_lim_r;
      CMD_ABS_TMR: rd_data = abs_tmr_r;
      CMD_EQ_TMR:  rd_data = eq_tmr_r;
      CMD_STATE:   rd_data = {3'h0, CHARGER_STATE_OUT};
      default:     rd_data = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b0;
    end else if (tick_cnt_r == 32'(TICK_CNT - 1)) begin
      tick_cnt_r <= 32'h00000000;
      tick_r <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h00000001;
      tick_r <= 1'b0;
    end
  end

  assign taper_hit = IBAT_IN < $signed(taper_r);
  assign abs_done  = abs_tmr_r > abs_lim_r;
  assign eq_done   = eq_tmr_r >= eq_lim_r;

  always_comb begin
    ph_nxt = ph_r;
    case (ph_r)
      AEPC_P_SUSP: if (!susp_r) ph_nxt = AEPC_P_CCCV;
      AEPC_P_CCCV: begin
        if (susp_r) begin
          ph_nxt = AEPC_P_SUSP;
        end else if (CV_REACHED_IN && !absorbed_r) begin
          if (abs_add_r != 6'h00) ph_nxt = AEPC_P_ABSORB;
          else if (eqreq_r) ph_nxt = AEPC_P_EQUAL;
        end
      end
      AEPC_P_ABSORB: begin
        if (susp_r) ph_nxt = AEPC_P_SUSP;
        else if (abs_done || taper_hit) ph_nxt = eqreq_r ? AEPC_P_EQUAL : AEPC_P_CCCV;
      end
      AEPC_P_EQUAL: begin
        if (susp_r) ph_nxt = AEPC_P_SUSP;
        else if (eq_done || !eqreq_r) ph_nxt = AEPC_P_CCCV;
      end
      default: ph_nxt = AEPC_P_CCCV;
    endcase
  end

  // absorbed_r keeps a finished cycle from re-entering absorb until suspension
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      ph_r <= AEPC_P_CCCV;
      absorbed_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      if (ph_r == AEPC_P_SUSP) absorbed_r <= 1'b0;
      else if (ph_r != ph_nxt && ph_nxt != AEPC_P_SUSP && ph_r != AEPC_P_CCCV) absorbed_r <= 1'b1;
      else if (ph_r == AEPC_P_CCCV && ph_nxt == AEPC_P_EQUAL) absorbed_r <= 1'b1;
    end
  end

  // timers clear on entry, hold after
  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      abs_tmr_r <= 16'h0000;
      eq_tmr_r <= 16'h0000;
    end else begin
      if (ph_nxt == AEPC_P_ABSORB && ph_r != AEPC_P_ABSORB) abs_tmr_r <= 16'h0000;
      else if (ph_r == AEPC_P_ABSORB && tick_r && abs_tmr_r != TMR_MAX)
        abs_tmr_r <= abs_tmr_r + 16'h0001;
      if (ph_nxt == AEPC_P_EQUAL && ph_r != AEPC_P_EQUAL) eq_tmr_r <= 16'h0000;
      else if (ph_r == AEPC_P_EQUAL && tick_r && eq_tmr_r != TMR_MAX)
        eq_tmr_r <= eq_tmr_r + 16'h0001;
    end
  end

  assign sum_abs = {1'b0, vcharge_r} + {1'b0, abs_add_r};
  assign sum_eq  = {1'b0, vcharge_r} + {1'b0, eq_add_r};

  always_comb begin
    case (ph_r)
      AEPC_P_ABSORB: code_nxt = sum_abs[6] ? CODE_MAX : sum_abs[5:0];
      AEPC_P_EQUAL:  code_nxt = sum_eq[6] ? CODE_MAX : sum_eq[5:0];
      default:       code_nxt = vcharge_r;
    endcase
  end

  // phase slopes; the normal phase reuses the absorb slope
  always_comb begin
    slope = (ph_r == AEPC_P_EQUAL) ? TC_EQ_UV_C : TC_ABS_UV_C;
    comp = tcomp_r ? slope * (32'(BAT_TEMP_C_IN) - TC_REF_C) : 0;
    cell_uv = FLOOR_UV + $signed({26'h0, SERVO_CODE_OUT}) * STEP_UV - comp;
    // cold compensation may not lift past the cap
    if (cell_uv > CAP_UV) cell_uv = CAP_UV;
    else if (cell_uv < 0) cell_uv = 0;
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      SERVO_CODE_OUT <= RST_VCHARGE;
      VTARGET_UV_OUT <= 26'h0000000;
    end else begin
      SERVO_CODE_OUT <= code_nxt;
      VTARGET_UV_OUT <= 26'(cell_uv * (32'(CELL_FACTOR_IN) + 1));
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RESETN_IN) begin
      CHARGER_STATE_OUT <= ST_CCCV;
      EQUALIZE_REQ_OUT <= 1'b0;
    end else begin
      EQUALIZE_REQ_OUT <= eqreq_r;
      case (ph_nxt)
        AEPC_P_SUSP:   CHARGER_STATE_OUT <= ST_SUSPENDED;
        AEPC_P_ABSORB: CHARGER_STATE_OUT <= ST_ABSORB;
        AEPC_P_EQUAL:  CHARGER_STATE_OUT <= ST_EQUALIZE;
        default:       CHARGER_STATE_OUT <= ST_CCCV;
      endcase
    end
  end

  property p_base_track;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r == AEPC_P_CCCV |=> SERVO_CODE_OUT == $past(vcharge_r);
  endproperty
  a_base_track: assert property (p_base_track) else $error("code not base");

  property p_absorb_sum;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r == AEPC_P_ABSORB && !sum_abs[6] |=> SERVO_CODE_OUT == $past(sum_abs[5:0]);
  endproperty
  a_absorb_sum: assert property (p_absorb_sum) else $error("absorb sum wrong");

  property p_cap;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ##1 VTARGET_UV_OUT <= 26'(CAP_UV * (32'($past(CELL_FACTOR_IN)) + 1));
  endproperty
  a_cap: assert property (p_cap) else $error("target above cap");

  property p_skip;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r == AEPC_P_CCCV && abs_add_r == 6'h00 |=> ph_r != AEPC_P_ABSORB;
  endproperty
  a_skip: assert property (p_skip) else $error("absorb not skipped");

  property p_abs_end;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r == AEPC_P_ABSORB && (abs_tmr_r > abs_lim_r || IBAT_IN < $signed(taper_r))
      |=> ph_r != AEPC_P_ABSORB;
  endproperty
  a_abs_end: assert property (p_abs_end) else $error("absorb overran");

  property p_eq_end;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r == AEPC_P_EQUAL && eq_tmr_r >= eq_lim_r && !wr_stb
      |=> !eqreq_r && ph_r != AEPC_P_EQUAL;
  endproperty
  a_eq_end: assert property (p_eq_end) else $error("equalize overran");

  property p_onehot;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    $onehot(CHARGER_STATE_OUT);
  endproperty
  a_onehot: assert property (p_onehot) else $error("state not one-hot");

  property p_tmr_hold;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r != AEPC_P_ABSORB && ph_nxt != AEPC_P_ABSORB |=> $stable(abs_tmr_r);
  endproperty
  a_tmr_hold: assert property (p_tmr_hold) else $error("timer moved");

  property p_tcomp_off;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    !tcomp_r |=> VTARGET_UV_OUT == 26'((FLOOR_UV + 32'($past(SERVO_CODE_OUT)) * STEP_UV)
                                       * (32'($past(CELL_FACTOR_IN)) + 1));
  endproperty
  a_tcomp_off: assert property (p_tcomp_off) else $error("comp applied");

  property p_eq_sum;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r == AEPC_P_EQUAL && !sum_eq[6] |=> SERVO_CODE_OUT == $past(sum_eq[5:0]);
  endproperty
  a_eq_sum: assert property (p_eq_sum) else $error("equalize sum wrong");

  property p_code_sat;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (ph_r == AEPC_P_ABSORB && sum_abs[6]) || (ph_r == AEPC_P_EQUAL && sum_eq[6])
      |=> SERVO_CODE_OUT == CODE_MAX;
  endproperty
  a_code_sat: assert property (p_code_sat) else $error("code not saturated");

  property p_susp_clear;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    susp_r && !(wr_stb && cmd == CMD_CONFIG) |=> !eqreq_r;
  endproperty
  a_susp_clear: assert property (p_susp_clear) else $error("request kept in suspend");

  property p_state_map;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    (ph_r == AEPC_P_ABSORB) == (CHARGER_STATE_OUT == ST_ABSORB)
      && (ph_r == AEPC_P_EQUAL) == (CHARGER_STATE_OUT == ST_EQUALIZE);
  endproperty
  a_state_map: assert property (p_state_map) else $error("phase report wrong");

  property p_abs_entry;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r != AEPC_P_ABSORB && ph_nxt == AEPC_P_ABSORB |=> abs_tmr_r == 16'h0000;
  endproperty
  a_abs_entry: assert property (p_abs_entry) else $error("absorb timer not cleared");

  property p_eq_entry;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r != AEPC_P_EQUAL && ph_nxt == AEPC_P_EQUAL |=> eq_tmr_r == 16'h0000;
  endproperty
  a_eq_entry: assert property (p_eq_entry) else $error("equalize timer not cleared");

  property p_eq_count;
    @(posedge CLK_IN) disable iff (!RESETN_IN)
    ph_r == AEPC_P_EQUAL && tick_r && eq_tmr_r != TMR_MAX
      |=> eq_tmr_r == $past(eq_tmr_r) + 16'h0001;
  endproperty
  a_eq_count: assert property (p_eq_count) else $error("equalize timer missed tick");

endmodule : aepc_ctl

/* sim/aepc_host.sv */
/*
  host model on the two-wire register port: word write and word read.
  assumes a pull-up on SDA resolved by the bench; phases of 10 clocks.
*/
`timescale 1ns/1ns
module aepc_host #(
  parameter logic [6:0] ADDR = 7'h68
) (
  input  wire logic clk_in,
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  int nacks = 0;
  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end
  // half phase longer than the 8 clocks the port needs
  task automatic hp();
    repeat (10) @(negedge clk_in);
  endtask : hp
  task automatic clk9(input logic low);
    sda_low_out = low;
    hp();
    scl_out = 1'b1;
    hp();
  endtask : clk9
  task automatic tx(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      clk9(!b[i]);
      scl_out = 1'b0;
    end
    clk9(1'b0);
    if (sda_in !== 1'b0) nacks++;
    scl_out = 1'b0;
  endtask : tx
  task automatic rx(output logic [7:0] b, input logic ack);
    for (int i = 7; i >= 0; i--) begin
      clk9(1'b0);
      b[i] = sda_in;
      scl_out = 1'b0;
    end
    clk9(ack);
    scl_out = 1'b0;
  endtask : rx
  // also serves as repeated start: scl is low on entry
  task automatic start();
    clk9(1'b0);
    sda_low_out = 1'b1;
    hp();
    scl_out = 1'b0;
  endtask : start
  task automatic stop();
    clk9(1'b1);
    sda_low_out = 1'b0;
    hp();
  endtask : stop
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d);
    start();
    tx({ADDR, 1'b0});
    tx(cmd);
    tx(d[7:0]);
    tx(d[15:8]);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] cmd, output logic [15:0] d);
    start();
    tx({ADDR, 1'b0});
    tx(cmd);
    start();
    tx({ADDR, 1'b1});
    rx(d[7:0], 1'b1);
    rx(d[15:8], 1'b0);
    stop();
  endtask : rd
endmodule : aepc_host

/* sim/aepc_ctl_test.sv */
/*
  testbench for the phase control block: registers, absorb, equalize, skip.
  assumes the host model of aepc_host and a tick of 20 clocks.
*/
`timescale 1ns/1ns
module aepc_ctl_test;
  import aepc_pkg::*;
  logic               clk = 1'b0;
  logic               rstn;
  logic               cv;
  logic        [1:0]  cf;
  logic signed [15:0] ibat;
  logic signed [7:0]  temp;
  wire                scl, host_low, sda_oe, sda_o;
  wire                sda = !(host_low || (sda_oe && !sda_o));
  wire         [5:0]  servo;
  wire         [25:0] vt;
  wire         [12:0] st;
  wire                eqr;
  int                 n_mismatch = 0;
  int                 num_checks = 0;
  always #4 clk = !clk;
  aepc_ctl #(.TICK_CNT(20)) DUT (.CLK_IN(clk), .RESETN_IN(rstn), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe), .CELL_FACTOR_IN(cf),
    .IBAT_IN(ibat), .BAT_TEMP_C_IN(temp), .CV_REACHED_IN(cv), .SERVO_CODE_OUT(servo),
    .VTARGET_UV_OUT(vt), .CHARGER_STATE_OUT(st), .EQUALIZE_REQ_OUT(eqr));
  aepc_host host (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_low_out(host_low));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic rdchk(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] d;
    host.rd(c, d);
    chk(d, e);
  endtask : rdchk
  // bounded wait, then let code and target settle
  task automatic wait_st(input logic [12:0] s);
    for (int n = 0; n < 3000 && st !== s; n++) @(negedge clk);
    chk(st, s);
    repeat (3) @(negedge clk);
  endtask : wait_st
  // two cells: cell factor 1 in every check but the four-cell one
  function automatic logic [25:0] vtv(input int code, input int comp);
    return 26'(2 * (FLOOR_UV + code * STEP_UV - comp));
  endfunction : vtv
  task automatic t_reset();
    logic [7:0]  c[10] = '{8'h1B, 8'h1C, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h32,
                           8'h33, 8'h14};
    logic [15:0] e[10] = '{16'h0015, 16'h0888, 16'h0002, 16'h0015, 16'h1518, 16'h002A,
                           16'h0E10, 16'h0000, 16'h0000, 16'h0000};
    chk(servo, 6'h15);
    chk(vt, vtv(21, 0));
    chk(st, 13'h0040);
    for (int i = 0; i < 10; i++)
      rdchk(c[i], e[i]);
  endtask : t_reset
  task automatic t_regs();
    host.wr(8'h1B, 16'h001E);
    host.wr(8'h2B, 16'h0003);
    host.wr(8'h2D, 16'h0002);
    host.wr(8'h32, 16'h0005);
    rdchk(8'h32, 16'h0000);
    temp = 8'h23;
    host.wr(8'h29, 16'h0000);
    repeat (3) @(negedge clk);
    chk(servo, 6'h1E);
    chk(vt, vtv(30, 0));
    host.wr(8'h29, 16'h0002);
    repeat (3) @(negedge clk);
    chk(vt, vtv(30, 110000));
    // four cells: same per-cell level, twice the two-cell target
    cf = 2'h3;
    repeat (3) @(negedge clk);
    chk(vt, 26'(2 * vtv(30, 110000)));
    cf = 2'h1;
    rdchk(8'h29, 16'h0002);
    temp = 8'h19;
  endtask : t_regs
  task automatic t_absorb();
    cv = 1'b1;
    wait_st(13'h0200);
    chk(servo, 6'h33);
    chk(vt, vtv(51, 0));
    // absorb limit 3: leaves once the timer shows 4
    wait_st(13'h0040);
    rdchk(8'h32, 16'h0004);
  endtask : t_absorb
  task automatic t_equal();
    host.wr(8'h2B, 16'h012C);
    host.wr(8'h14, 16'h0020);
    wait_st(13'h0100);
    host.wr(8'h14, 16'h0001);
    wait_st(13'h0200);
    chk(eqr, 1'b1);
    ibat = 16'h03E8;
    wait_st(13'h0400);
    chk(servo, 6'h3F);
    chk(vt, vtv(63, 0));
    temp = 8'h23;
    repeat (3) @(negedge clk);
    chk(vt, vtv(63, 114000));
    // cold side: compensation would lift the cell past the cap
    temp = 8'h0F;
    repeat (3) @(negedge clk);
    chk(vt, 26'(2 * CAP_UV));
    wait_st(13'h0040);
    chk(eqr, 1'b0);
    rdchk(8'h33, 16'h0002);
    rdchk(8'h14, 16'h0000);
    ibat = 16'h0FA0;
    temp = 8'h19;
  endtask : t_equal
  task automatic t_skip();
    host.wr(8'h2D, 16'h00C8);
    host.wr(8'h14, 16'h0020);
    wait_st(13'h0100);
    host.wr(8'h2A, 16'h0000);
    host.wr(8'h2C, 16'h0005);
    host.wr(8'h14, 16'h0001);
    wait_st(13'h0400);
    chk(servo, 6'h23);
    host.wr(8'h14, 16'h0000);
    wait_st(13'h0040);
    chk(eqr, 1'b0);
  endtask : t_skip
  // power cycle mid-run drops a pending request and reloads defaults
  task automatic t_power();
    host.wr(8'h14, 16'h0001);
    chk(eqr, 1'b1);
    cv = 1'b0;
    rstn = 1'b0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    chk(eqr, 1'b0);
    chk(servo, 6'h15);
    rdchk(8'h14, 16'h0000);
    rdchk(8'h34, 16'h0040);
    rdchk(8'h2A, 16'h0015);
  endtask : t_power
  task automatic end_of_test();
    $display("Mismatches %0d of %0d checks", n_mismatch, num_checks);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_of_test
  // whole run is about 31000 clocks
  initial begin
    #640000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    rstn = 1'b0;
    cv = 1'b0;
    cf = 2'h1;
    ibat = 16'h0FA0;
    temp = 8'h19;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (8) @(negedge clk);
    t_reset();
    t_regs();
    t_absorb();
    t_equal();
    t_skip();
    t_power();
    chk(host.nacks, 0);
    end_of_test();
  end
endmodule : aepc_ctl_test
